// *** mbs_bus_slave.sv ***
// Purpose: device side of a multiplexed address/data host bus
// Assumes: host pins are asynchronous to ref_clk and change slowly against it
// Notes: all pin levels are seen two ref_clk cycles late, consistently
// Notes on behaviour
// [RQ1] address in first state, data afterwards
// [RQ2] latch address; internal only when selected
// [RQ3] float unselected; drive only read data states; code keeps driving after a mid-cycle select drop until the status kind changes
// [RQ4] hold high-byte enable from strobe's falling edge
// [RQ5] steer read data by enable and bit0
// [RQ6] status pins are inputs only
// [RQ7] decode fetch, memory read, passive codes
// [RQ8] acknowledge low on access or vector supply
// [RQ9] host selects kernel memory; low 14 bits index
// [RQ10] io select routes io read/write accesses
// [RQ11] bus logic timed by the shared clock
// [RQ12] passive status starts nothing, lines float
`timescale 1ns/1ps
module mbs_bus_slave (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [mbs_pkg::AD_W-1:0] adIn,
    output logic [mbs_pkg::AD_W-1:0] adOut,
    output logic [mbs_pkg::AD_W-1:0] adOe_n,
    input wire logic addrLatchStrobe,
    input wire logic highByteEnable_n,
    input wire logic [mbs_pkg::STATUS_W-1:0] cycleStatusCode,
    input wire logic kernelMemSelect_n,
    input wire logic periphIoSelect_n,
    output logic accessAck_n,
    input wire logic vectorSupply,
    input wire logic [mbs_pkg::AD_W-1:0] readWord,
    output mbs_pkg::mbs_access_type access,
    output logic accessStart,
    output logic [mbs_pkg::KERNEL_ADDR_W-1:0] kernelIndex,
    output logic [mbs_pkg::AD_W-1:0] writeWord,
    output logic writeStrobe
);
    localparam int SYNC_W = mbs_pkg::AD_W + mbs_pkg::STATUS_W + 4;

    logic [SYNC_W-1:0] syncBus;
    logic [mbs_pkg::AD_W-1:0] adS;
    logic aleS;
    logic bheS_n;
    logic [mbs_pkg::STATUS_W-1:0] statusS;
    logic memSelS_n;
    logic ioSelS_n;
    logic aleDly_r;
    logic aleFall;
    mbs_pkg::mbs_kind_type kindNow;
    mbs_pkg::mbs_state_type state_r;
    mbs_pkg::mbs_state_type state_nxt;
    mbs_pkg::mbs_access_type access_r;
    logic selected_r;
    logic selectNow;
    logic readKind;
    logic driveNow;
    logic [mbs_pkg::AD_W-1:0] laneMask;
    logic [1:0] steerSel;
    logic [mbs_pkg::AD_W-1:0] adOut_r;
    logic [mbs_pkg::AD_W-1:0] writeWord_r;
    logic accessStart_r;
    logic writeStrobe_r;
    logic accessAck_n_r;

    // every host pin, status included, is only ever sampled here [RQ6] [RQ11]
    mbs_sync #(
        .W(SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .asyncIn({adIn, addrLatchStrobe, highByteEnable_n, cycleStatusCode,
                  kernelMemSelect_n, periphIoSelect_n}),
        .syncOut(syncBus)
    );

    assign {adS, aleS, bheS_n, statusS, memSelS_n, ioSelS_n} = syncBus;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aleDly_r <= 1'b0;
        end else begin
            aleDly_r <= aleS;
        end
    end

    // trailing edge of the address strobe closes the first bus state
    assign aleFall = aleDly_r & ~aleS;

    always_comb begin
        kindNow = mbs_pkg::KIND_PASSIVE;
        if (statusS[2:1] == mbs_pkg::ST_PASSIVE_HI) begin
            kindNow = mbs_pkg::KIND_PASSIVE; // [RQ7]
        end else begin
            case (statusS)
                mbs_pkg::ST_FETCH: kindNow = mbs_pkg::KIND_FETCH; // [RQ7]
                mbs_pkg::ST_MEM_RD: kindNow = mbs_pkg::KIND_MEM_RD; // [RQ7]
                mbs_pkg::ST_PASSIVE_LO: kindNow = mbs_pkg::KIND_PASSIVE; // [RQ7]
                mbs_pkg::ST_IO_RD: kindNow = mbs_pkg::KIND_IO_RD;
                mbs_pkg::ST_IO_WR: kindNow = mbs_pkg::KIND_IO_WR;
                mbs_pkg::ST_VECTOR: kindNow = mbs_pkg::KIND_VECTOR;
                default: kindNow = mbs_pkg::KIND_PASSIVE;
            endcase
        end
    end

    // memory kinds answer to the kernel select, io kinds to the io select
    always_comb begin
        case (kindNow)
            mbs_pkg::KIND_FETCH,
            mbs_pkg::KIND_MEM_RD: selectNow = ~memSelS_n; // [RQ2] [RQ9]
            mbs_pkg::KIND_IO_RD,
            mbs_pkg::KIND_IO_WR: selectNow = ~ioSelS_n; // [RQ2] [RQ10]
            default: selectNow = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mbs_pkg::S_IDLE: begin
                if (aleS) begin
                    state_nxt = mbs_pkg::S_ADDR; // [RQ1]
                end
            end
            mbs_pkg::S_ADDR: begin
                if (aleFall) begin
                    // a passive code after the strobe starts no access [RQ12]
                    if (kindNow == mbs_pkg::KIND_PASSIVE) begin
                        state_nxt = mbs_pkg::S_IDLE;
                    end else begin
                        state_nxt = mbs_pkg::S_DATA; // [RQ1]
                    end
                end
            end
            mbs_pkg::S_DATA: begin
                if (kindNow == mbs_pkg::KIND_PASSIVE || aleS) begin
                    state_nxt = mbs_pkg::S_IDLE;
                end
            end
            default: state_nxt = mbs_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r <= mbs_pkg::S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // address and byte enable are held from the strobe's falling edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            access_r <= '0;
            selected_r <= 1'b0;
        end else if (state_r == mbs_pkg::S_ADDR && aleFall) begin
            access_r.addr <= adS; // [RQ2]
            access_r.highByteEnable_n <= bheS_n; // [RQ4]
            access_r.kind <= kindNow;
            selected_r <= selectNow; // [RQ2]
        end else if (state_r == mbs_pkg::S_DATA && state_nxt == mbs_pkg::S_IDLE) begin
            selected_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            accessStart_r <= 1'b0;
        end else begin
            accessStart_r <= (state_r == mbs_pkg::S_ADDR) && aleFall && selectNow; // [RQ12]
        end
    end

    assign readKind = (access_r.kind == mbs_pkg::KIND_FETCH)
                   || (access_r.kind == mbs_pkg::KIND_MEM_RD)
                   || (access_r.kind == mbs_pkg::KIND_IO_RD);

    // a select that drops mid-cycle floats the lines only once the status kind also changes
    assign driveNow = (state_r == mbs_pkg::S_DATA) && selected_r && readKind
                   && (selectNow || kindNow == access_r.kind); // [RQ3]

    always_comb begin
        laneMask = '0;
        case ({access_r.highByteEnable_n, access_r.addr[0]})
            mbs_pkg::STEER_WORD: laneMask = '1; // [RQ5]
            mbs_pkg::STEER_UPPER_HI: laneMask[mbs_pkg::HI_LSB +: mbs_pkg::BYTE_W] = '1;
            mbs_pkg::STEER_LOWER_LO: laneMask[mbs_pkg::LO_LSB +: mbs_pkg::BYTE_W] = '1;
            mbs_pkg::STEER_UPPER_LO: laneMask[mbs_pkg::LO_LSB +: mbs_pkg::BYTE_W] = '1;
            default: laneMask = '0;
        endcase
    end

    // a fresh latch steers its first data cycle, so the fold follows the captured pins
    assign steerSel = (state_r == mbs_pkg::S_ADDR && aleFall) ? {bheS_n, adS[0]}
                    : {access_r.highByteEnable_n, access_r.addr[0]};

    // the upper byte is folded onto the low lanes for odd byte reads with the high-byte enable inactive
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            adOut_r <= '0;
        end else if (steerSel == mbs_pkg::STEER_UPPER_LO) begin
            adOut_r <= {readWord[mbs_pkg::HI_LSB +: mbs_pkg::BYTE_W],
                        readWord[mbs_pkg::HI_LSB +: mbs_pkg::BYTE_W]}; // [RQ5]
        end else begin
            adOut_r <= readWord; // [RQ5]
        end
    end

    assign adOut = adOut_r;
    assign adOe_n = driveNow ? ~laneMask : '1; // [RQ3] [RQ12]

    // write data is taken on the last data cycle, when it has settled longest
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            writeWord_r <= '0;
            writeStrobe_r <= 1'b0;
        end else begin
            writeStrobe_r <= 1'b0;
            if (state_r == mbs_pkg::S_DATA && selected_r
                && access_r.kind == mbs_pkg::KIND_IO_WR) begin
                writeWord_r <= adS; // [RQ10]
                writeStrobe_r <= (state_nxt == mbs_pkg::S_IDLE);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            accessAck_n_r <= 1'b1;
        end else begin
            accessAck_n_r <= ~((state_nxt == mbs_pkg::S_DATA)
                             && ((state_r == mbs_pkg::S_DATA) ? selected_r : selectNow)
                             || (state_nxt == mbs_pkg::S_DATA && vectorSupply
                                 && kindNow == mbs_pkg::KIND_VECTOR)); // [RQ8]
        end
    end

    assign access = access_r;
    assign accessStart = accessStart_r;
    assign kernelIndex = access_r.addr[mbs_pkg::KERNEL_ADDR_W-1:0]; // [RQ9]
    assign writeWord = writeWord_r;
    assign writeStrobe = writeStrobe_r;
    assign accessAck_n = accessAck_n_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_float_unselected: assert property (!selected_r |-> adOe_n == '1) // [RQ3]
        else $error("lines driven while not selected");
    a_no_write_drive: assert property (
        (access_r.kind == mbs_pkg::KIND_IO_WR) |-> adOe_n == '1) // [RQ3]
        else $error("lines driven during a write");
    a_passive_quiet: assert property (
        (state_r == mbs_pkg::S_ADDR && aleFall && kindNow == mbs_pkg::KIND_PASSIVE)
        |=> !accessStart && state_r == mbs_pkg::S_IDLE) // [RQ12]
        else $error("passive status began an access");
    a_bhe_capture: assert property (
        (state_r == mbs_pkg::S_ADDR && aleFall)
        |=> access.highByteEnable_n == $past(bheS_n)) // [RQ4]
        else $error("byte enable not held from strobe fall");
    a_addr_capture: assert property (
        (state_r == mbs_pkg::S_ADDR && aleFall) |=> (access.addr == $past(adS))
        ##1 $stable(access.addr)[*2]) // [RQ2]
        else $error("address not latched at strobe fall");
    a_word_lanes: assert property (
        (driveNow && {access_r.highByteEnable_n, access_r.addr[0]}
         == mbs_pkg::STEER_WORD) |-> adOe_n == '0) // [RQ5]
        else $error("word read not on all lanes");
    a_upper_low_lanes: assert property (
        (driveNow && {access_r.highByteEnable_n, access_r.addr[0]}
         == mbs_pkg::STEER_UPPER_LO) |-> adOe_n == 16'hFF00
         && adOut[7:0] == $past(readWord[15:8])) // [RQ5]
        else $error("odd byte not folded onto low lanes");
    a_ack_on_access: assert property (
        (state_r == mbs_pkg::S_DATA && selected_r && state_nxt == mbs_pkg::S_DATA)
        |=> !accessAck_n) // [RQ8]
        else $error("acknowledge missing during access");
    a_fetch_decode: assert property (
        (statusS == mbs_pkg::ST_FETCH) |-> kindNow == mbs_pkg::KIND_FETCH) // [RQ7]
        else $error("fetch code misdecoded");
endmodule

// *** mbs_bus_slave_test.sv ***
// Purpose: self-checking bench for the multiplexed host bus slave
// Assumes: host states last several clocks, so the pin synchroniser keeps up
// Notes: vector cycles never drive lanes; their acknowledge follows vectorSupply
`timescale 1ns/1ps
module mbs_bus_slave_test;
    logic ref_clk;
    logic reset;
    logic [15:0] adIn;
    logic [15:0] adOut;
    logic [15:0] adOe_n;
    logic addrLatchStrobe;
    logic highByteEnable_n;
    logic [2:0] cycleStatusCode;
    logic kernelMemSelect_n;
    logic periphIoSelect_n;
    logic accessAck_n;
    logic vectorSupply;
    logic [15:0] readWord;
    mbs_pkg::mbs_access_type access;
    mbs_pkg::mbs_access_type seenAccess;
    logic accessStart;
    logic [13:0] kernelIndex;
    logic [15:0] writeWord;
    logic [15:0] seenWrite;
    logic writeStrobe;
    int miscompares;
    int checked;
    int startCount;
    int writeCount;

    mbs_bus_slave dut (.ref_clk(ref_clk), .reset(reset), .adIn(adIn), .adOut(adOut),
        .adOe_n(adOe_n), .addrLatchStrobe(addrLatchStrobe), .highByteEnable_n(highByteEnable_n),
        .cycleStatusCode(cycleStatusCode), .kernelMemSelect_n(kernelMemSelect_n),
        .periphIoSelect_n(periphIoSelect_n), .accessAck_n(accessAck_n),
        .vectorSupply(vectorSupply), .readWord(readWord), .access(access),
        .accessStart(accessStart), .kernelIndex(kernelIndex), .writeWord(writeWord),
        .writeStrobe(writeStrobe));

    mbs_host_model host (.ref_clk(ref_clk), .adOut(adOut), .adOe_n(adOe_n), .adIn(adIn),
        .addrLatchStrobe(addrLatchStrobe), .highByteEnable_n(highByteEnable_n),
        .cycleStatusCode(cycleStatusCode), .kernelMemSelect_n(kernelMemSelect_n),
        .periphIoSelect_n(periphIoSelect_n));

    always #10 ref_clk = ~ref_clk;

    // pulses are looked at mid-cycle, well away from the edge that launches them
    always @(negedge ref_clk) begin
        if (accessStart === 1'b1) begin
            startCount++;
            seenAccess = access;
        end
        if (writeStrobe === 1'b1) begin
            writeCount++;
            seenWrite = writeWord;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic mbs_pkg::mbs_kind_type kindOf(input logic [2:0] st);
        case (st)
            mbs_pkg::ST_FETCH: return mbs_pkg::KIND_FETCH;
            mbs_pkg::ST_MEM_RD: return mbs_pkg::KIND_MEM_RD;
            mbs_pkg::ST_IO_RD: return mbs_pkg::KIND_IO_RD;
            mbs_pkg::ST_IO_WR: return mbs_pkg::KIND_IO_WR;
            mbs_pkg::ST_VECTOR: return mbs_pkg::KIND_VECTOR;
            default: return mbs_pkg::KIND_PASSIVE;
        endcase
    endfunction

    // expected {lane enables, driven data} for one read
    function automatic logic [31:0] steer(input logic [1:0] sel, input logic [15:0] w,
                                          input logic on);
        if (!on) return {16'hFFFF, 16'h0000};
        case (sel)
            mbs_pkg::STEER_WORD: return {16'h0000, w};
            mbs_pkg::STEER_UPPER_HI: return {16'h00FF, w[15:8], 8'h00};
            mbs_pkg::STEER_LOWER_LO: return {16'hFF00, 8'h00, w[7:0]};
            default: return {16'hFF00, 8'h00, w[15:8]};
        endcase
    endfunction

    task automatic runCycle(input logic [2:0] st, input logic [15:0] addr, input logic bheN,
                            input logic selN);
        mbs_pkg::mbs_kind_type k;
        logic isIo;
        logic sel;
        logic wr;
        logic [15:0] wd;
        k = kindOf(st);
        isIo = (k == mbs_pkg::KIND_IO_RD) || (k == mbs_pkg::KIND_IO_WR);
        sel = !selN && (isIo || k == mbs_pkg::KIND_FETCH || k == mbs_pkg::KIND_MEM_RD);
        wr = sel && (k == mbs_pkg::KIND_IO_WR);
        wd = 16'($urandom);
        readWord = 16'($urandom);
        vectorSupply = 1'($urandom);
        startCount = 0;
        writeCount = 0;
        fork
            host.busCycle(st, addr, bheN, (isIo || k == mbs_pkg::KIND_VECTOR) ? 1'b1 : selN,
                          isIo ? selN : 1'b1, wd);
            begin
                repeat (14) @(negedge ref_clk);
                check({adOe_n, adOut & ~adOe_n}, steer({bheN, addr[0]}, readWord, sel && !wr),
                      "lanes");
                check(32'(accessAck_n), (k == mbs_pkg::KIND_VECTOR) ? 32'(!vectorSupply)
                      : 32'(!sel), "ack");
            end
        join
        check(32'(startCount), 32'(sel), "start count");
        if (sel) begin
            check(32'(seenAccess), 32'({addr, bheN, k}), "access");
            check(32'(kernelIndex), 32'(addr[13:0]), "kernel index");
        end
        check(32'(writeCount), 32'(wr), "write count");
        if (wr) check(32'(seenWrite), 32'(wd), "write word");
        check({adOe_n, 15'h0000, accessAck_n}, {16'hFFFF, 16'h0001}, "idle");
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        $display("ERROR t=%0t run did not finish", $time);
        end_sim();
    end

    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        readWord = '0;
        vectorSupply = 1'b0;
        miscompares = 0;
        checked = 0;
        void'($urandom(11));
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        repeat (2) @(negedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            runCycle(mbs_pkg::ST_MEM_RD, (16'($urandom) & 16'hFFFE) | 16'(i[0]), i[1], 1'b0);
        end
        $display("test steering done");
        runCycle(mbs_pkg::ST_FETCH, 16'h3FFF, 1'b0, 1'b0);
        runCycle(mbs_pkg::ST_IO_RD, 16'h00A5, 1'b1, 1'b0);
        runCycle(mbs_pkg::ST_IO_WR, 16'h0042, 1'b0, 1'b0);
        runCycle(mbs_pkg::ST_VECTOR, 16'h0000, 1'b0, 1'b0);
        runCycle(mbs_pkg::ST_MEM_RD, 16'h1234, 1'b0, 1'b1);
        $display("test kinds done");
        for (int i = 0; i < 3; i++) runCycle(i == 0 ? 3'h3 : 3'(5 + i), 16'h00FF, 1'b0, 1'b0);
        $display("test passive done");
        for (int i = 0; i < 40; i++) begin
            runCycle(3'($urandom), 16'($urandom), 1'($urandom), 1'($urandom));
        end
        $display("test random done");
        end_sim();
    end
endmodule

// *** mbs_host_model.sv ***
// Purpose: host side of the multiplexed bus, one whole bus cycle per call
// Assumes: each bus state lasts several ref_clk periods, as a slow host would
// Notes: released lanes toggle every cycle instead of keeping the last level
`timescale 1ns/1ps
module mbs_host_model (
    input wire logic ref_clk,
    input wire logic [mbs_pkg::AD_W-1:0] adOut,
    input wire logic [mbs_pkg::AD_W-1:0] adOe_n,
    output logic [mbs_pkg::AD_W-1:0] adIn,
    output logic addrLatchStrobe,
    output logic highByteEnable_n,
    output logic [mbs_pkg::STATUS_W-1:0] cycleStatusCode,
    output logic kernelMemSelect_n,
    output logic periphIoSelect_n
);
    logic [mbs_pkg::AD_W-1:0] hostDrive;
    logic [mbs_pkg::AD_W-1:0] lastLevel;
    logic hostOn;

    // device lanes win, then the host, else no one drives the wire
    always_comb begin
        for (int i = 0; i < mbs_pkg::AD_W; i++) begin
            adIn[i] = !adOe_n[i] ? adOut[i] : (hostOn ? hostDrive[i] : ~lastLevel[i]);
        end
    end

    always @(posedge ref_clk) lastLevel <= adIn;

    initial begin
        lastLevel = '0;
        hostDrive = '0;
        hostOn = 1'b1;
        addrLatchStrobe = 1'b0;
        highByteEnable_n = 1'b1;
        cycleStatusCode = mbs_pkg::ST_PASSIVE_LO;
        kernelMemSelect_n = 1'b1;
        periphIoSelect_n = 1'b1;
    end

    task automatic busCycle(input logic [2:0] st, input logic [15:0] addr, input logic bheN,
                            input logic memN, input logic ioN, input logic [15:0] wdata);
        @(negedge ref_clk);
        hostOn = 1'b1;
        hostDrive = addr;
        cycleStatusCode = st;
        highByteEnable_n = bheN;
        kernelMemSelect_n = memN;
        periphIoSelect_n = ioN;
        addrLatchStrobe = 1'b1;
        repeat (4) @(negedge ref_clk);
        addrLatchStrobe = 1'b0;
        repeat (4) @(negedge ref_clk);
        // the enable pin carries other status after the strobe, so it must be latched
        highByteEnable_n = ~bheN;
        hostOn = (st == mbs_pkg::ST_IO_WR);
        hostDrive = wdata;
        repeat (6) @(negedge ref_clk);
        cycleStatusCode = mbs_pkg::ST_PASSIVE_LO;
        kernelMemSelect_n = 1'b1;
        periphIoSelect_n = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask
endmodule

// *** mbs_pkg.sv ***
// Purpose: shared constants and types for the multiplexed host bus slave
// Assumes: host pins are sampled by ref_clk after a two-stage synchroniser
// Notes: status codes are the raw levels of the three status pins
package mbs_pkg;
    localparam int AD_W = 16;
    localparam int BYTE_W = 8;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 8;
    localparam int KERNEL_ADDR_W = 14;
    localparam int STATUS_W = 3;
    localparam int SYNC_STAGES = 2;

    // status pin encodings
    localparam logic [2:0] ST_VECTOR = 3'h0;
    localparam logic [2:0] ST_IO_RD = 3'h1;
    localparam logic [2:0] ST_IO_WR = 3'h2;
    localparam logic [2:0] ST_PASSIVE_LO = 3'h3;
    localparam logic [2:0] ST_FETCH = 3'h4;
    localparam logic [2:0] ST_MEM_RD = 3'h5;
    localparam logic [1:0] ST_PASSIVE_HI = 2'h3;

    // high-byte enable and address bit zero, as {enable_n, bit0}
    localparam logic [1:0] STEER_WORD = 2'h0;
    localparam logic [1:0] STEER_UPPER_HI = 2'h1;
    localparam logic [1:0] STEER_LOWER_LO = 2'h2;
    localparam logic [1:0] STEER_UPPER_LO = 2'h3;

    typedef enum logic [2:0] {
        KIND_PASSIVE = 3'h0,
        KIND_FETCH = 3'h1,
        KIND_MEM_RD = 3'h2,
        KIND_IO_RD = 3'h3,
        KIND_IO_WR = 3'h4,
        KIND_VECTOR = 3'h5
    } mbs_kind_type;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_ADDR = 3'h2,
        S_DATA = 3'h4
    } mbs_state_type;

    typedef struct packed {
        logic [AD_W-1:0] addr;
        logic highByteEnable_n;
        mbs_kind_type kind;
    } mbs_access_type;
endpackage

// *** mbs_sync.sv ***
// Purpose: two flip-flop synchroniser for a group of host bus pins
// Assumes: each bit is a level; multi-bit groups settle before they are used
// Notes: the first stage is read only by the second stage
`timescale 1ns/1ps
module mbs_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_r;
    logic [W-1:0] stable_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            stable_r <= '0;
        end else begin
            meta_r <= asyncIn;
            stable_r <= meta_r;
        end
    end

    assign syncOut = stable_r;
endmodule
